// File: hdl/pimu_cfg.svh
`ifndef PIMU_CFG_SVH
`define PIMU_CFG_SVH

// Register byte offsets
`define PIMU_REG_MASK0      8'h00
`define PIMU_REG_CTRL       8'h40
`define PIMU_REG_STATUS     8'h44
`define PIMU_REG_ERRCODE    8'h48
`define PIMU_REG_PER0       8'h50
`define PIMU_REG_GRANT      8'h60
`define PIMU_REG_PEND0      8'h80

// Control bits
`define PIMU_CTRL_EI        0
`define PIMU_CTRL_DI        1
`define PIMU_CTRL_MASK_LOAD_INSTRUCTION     2
`define PIMU_CTRL_DONE      3

// Error code for out of range source words
`define PIMU_ERR_RANGE      16'h2003

// Interrupt numbers
`define PIMU_IRQ_SUPPLY     8'd34
`define PIMU_IRQ_TIMER0     8'd252

// Timing
`define PIMU_CLK_HZ         40000000
`define PIMU_TICK_MS        1
`define PIMU_CYC_PER_MS     ((`PIMU_CLK_HZ / 1000) * `PIMU_TICK_MS)
`define PIMU_PER0_MS        10'd100
`define PIMU_PER1_MS        10'd40
`define PIMU_PER2_MS        10'd20
`define PIMU_PER3_MS        10'd10
`define PIMU_PER_MIN_MS     10'd1
`define PIMU_PER_MAX_MS     10'd1000

// Source memory range for mask load
`define PIMU_SRC_LAST       16'hfff0

`endif

// File: hdl/pimu_pkg.sv
package pimu_pkg;
  typedef enum logic [1:0] {
    PIMU_IDLE   = 2'b00,
    PIMU_FETCH  = 2'b01,
    PIMU_STORE  = 2'b11
  } pimu_fsm_type;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } pimu_bus_type;

  typedef struct packed {
    logic        valid;
    logic [7:0]  num;
  } pimu_grant_type;
endpackage : pimu_pkg

// File: hdl/pimu_top.sv
`timescale 1ns/1ps
`include "pimu_cfg.svh"
// What this block does
// - Timer 252 period defaults 100 ms, programmable 1 to 1000 ms.
// - Timers 253, 254, 255 default 40, 20, 10 ms; programmable.
// - Each timer requests again every time its period elapses.
// - Timer interrupts sit at numbers 252 to 255.
// - Priority is fixed by number; smaller number wins.
// - Abnormal 24 V supply raises interrupt 34.
// - Mask bit one allows service only with global enable on.
// - Mask bit zero blocks service regardless of global enable.
// - Mask load copies sixteen source words into the mask bank.
// - Mask bank holds and keeps gating when no load runs.
// - Out of range source: skip, set error flag, code 2003.
// - Requests during service stay pending until service ends.
// - Among eligible requests the smallest number is granted.
// - Requests while disabled latch once, serviced after enable.
module pimu_top
  import pimu_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic [7:0]   addr,
  input  wire logic [31:0]  wdata,
  input  wire logic         wr,
  input  wire logic         rd,
  output logic      [31:0]  rdata,
  input  wire logic [33:0]  io_irq,
  input  wire logic         supply_bad,
  input  wire logic [211:0] ext_irq,
  output logic              src_rd,
  output logic      [15:0]  src_addr,
  input  wire logic [15:0]  src_data,
  output logic              irq_req,
  output logic      [7:0]   irq_num,
  output logic              error_flag
);
  typedef struct packed {
    pimu_fsm_type    fsm;
    logic [3:0]      idx;
    logic [15:0]     base;
    logic            gie;
    logic            busy;
    pimu_grant_type  grant;
    logic [255:0]    pend;
    logic            err;
    logic [15:0]     err_code;
    logic [3:0][9:0] per;
    logic [3:0][9:0] ms_cnt;
    logic [15:0]     pre;
    logic [31:0]     rdata;
    logic            src_rd;
    logic [15:0]     src_addr;
  } pimu_state_type;

  pimu_state_type s_q, s_d;
  pimu_bus_type   bus;
  logic [255:0]   mask;
  logic [255:0]   raw;
  logic [255:0]   elig;
  logic [3:0]     tick;
  logic [15:0]    mem_rdata;
  logic           mem_we;
  logic           tick_ms;

  assign bus = '{wr: wr, rd: rd, addr: addr, wdata: wdata};

  // Lowest set bit of a 256-bit vector
  function automatic pimu_grant_type pick_lowest(input logic [255:0] v);
    pimu_grant_type r;
    r = '{valid: 1'b0, num: 8'h00};
    for (int i = 255; i >= 0; i--) begin
      if (v[i]) r = '{valid: 1'b1, num: 8'(i)};
    end
    return r;
  endfunction : pick_lowest

  // Legal period, else keep old
  function automatic logic [9:0] clamp_per(input logic [31:0] v, input logic [9:0] old);
    if (v >= 32'(`PIMU_PER_MIN_MS) && v <= 32'(`PIMU_PER_MAX_MS)) return v[9:0];
    return old;
  endfunction : clamp_per

  pimu_word_mem u_mem (
    .clk   (clk),
    .rst   (rst),
    .ce    (ce),
    .we    (mem_we),
    .waddr (s_q.idx),
    .wdata (src_data),
    .raddr (bus.addr[5:2]),
    .rdata (mem_rdata),
    .flat  (mask)
  );

  // timer requests at top numbers, supply fault at 34
  assign raw = {tick, ext_irq, 5'h00, supply_bad, io_irq};

  genvar t;
  generate
    for (t = 0; t < 4; t++) begin : g_tick
      assign tick[t] = tick_ms && (s_q.ms_cnt[t] + 10'd1 >= s_q.per[t]);
    end
  endgenerate
  assign tick_ms = (s_q.pre == 16'(`PIMU_CYC_PER_MS - 1));

  assign elig = s_q.pend & mask;
  assign mem_we = (s_q.fsm == PIMU_STORE);

  // Next state
  always_comb begin
    s_d = s_q;
    s_d.src_rd = 1'b0;
    s_d.rdata = 32'h0000_0000;
    // Millisecond prescaler and period counters
    s_d.pre = tick_ms ? 16'h0000 : s_q.pre + 16'h0001;
    for (int i = 0; i < 4; i++) begin
      if (tick[i]) s_d.ms_cnt[i] = 10'h000;
      else if (tick_ms) s_d.ms_cnt[i] = s_q.ms_cnt[i] + 10'd1;
    end
    // latch requests, set wins over grant clear
    s_d.pend = s_q.pend | raw;
    // Bus writes
    if (bus.wr) begin
      if (bus.addr == `PIMU_REG_CTRL) begin
        if (bus.wdata[`PIMU_CTRL_EI]) s_d.gie = 1'b1;
        if (bus.wdata[`PIMU_CTRL_DI]) s_d.gie = 1'b0;
        if (bus.wdata[`PIMU_CTRL_DONE]) s_d.busy = 1'b0;
        if (bus.wdata[`PIMU_CTRL_MASK_LOAD_INSTRUCTION] && s_q.fsm == PIMU_IDLE) begin
          if (bus.wdata[31:16] > `PIMU_SRC_LAST) begin
            s_d.err = 1'b1;
            s_d.err_code = `PIMU_ERR_RANGE;
          end else begin
            s_d.base = bus.wdata[31:16];
            s_d.idx = 4'h0;
            s_d.fsm = PIMU_FETCH;
            s_d.src_rd = 1'b1;
            s_d.src_addr = bus.wdata[31:16];
          end
        end
      end else if (bus.addr == `PIMU_REG_STATUS) begin
        if (bus.wdata[0]) s_d.err = 1'b0;
      end else if (bus.addr >= `PIMU_REG_PER0 && bus.addr < `PIMU_REG_PER0 + 8'h10) begin
        s_d.per[bus.addr[3:2]] = clamp_per(bus.wdata, s_q.per[bus.addr[3:2]]);
      end
    end
    unique case (s_q.fsm)
      PIMU_IDLE: begin
      end
      PIMU_FETCH: s_d.fsm = PIMU_STORE;
      PIMU_STORE: begin
        if (s_q.idx == 4'hf) begin
          s_d.fsm = PIMU_IDLE;
        end else begin
          s_d.idx = s_q.idx + 4'h1;
          s_d.fsm = PIMU_FETCH;
          s_d.src_rd = 1'b1;
          s_d.src_addr = s_q.src_addr + 16'h0001;
        end
      end
      default: s_d.fsm = PIMU_IDLE;
    endcase
    s_d.grant.valid = 1'b0;
    if (s_q.gie && !s_q.busy && !s_q.grant.valid && |elig) begin
      s_d.grant = pick_lowest(elig);
      s_d.busy = 1'b1;
      s_d.pend[s_d.grant.num] = raw[s_d.grant.num];
    end
    // Register reads
    if (bus.rd) begin
      if (bus.addr == `PIMU_REG_STATUS) s_d.rdata = {28'h0, s_q.fsm != PIMU_IDLE, s_q.busy, s_q.gie, s_q.err};
      else if (bus.addr == `PIMU_REG_ERRCODE) s_d.rdata = {16'h0000, s_q.err_code};
      else if (bus.addr == `PIMU_REG_GRANT) s_d.rdata = {24'h0, s_q.grant.num};
      else if (bus.addr >= `PIMU_REG_PER0 && bus.addr < `PIMU_REG_PER0 + 8'h10)
        s_d.rdata = {22'h0, s_q.per[bus.addr[3:2]]};
      else if (bus.addr >= `PIMU_REG_PEND0) s_d.rdata = s_q.pend[{bus.addr[4:2], 5'h00} +: 32];
    end
  end

  // Mask word read comes from the memory register
  logic rd_mask_q;

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
      s_q.per[0] <= `PIMU_PER0_MS;
      s_q.per[1] <= `PIMU_PER1_MS;
      s_q.per[2] <= `PIMU_PER2_MS;
      s_q.per[3] <= `PIMU_PER3_MS;
      rd_mask_q <= 1'b0;
    end else if (ce) begin
      s_q <= s_d;
      rd_mask_q <= bus.rd && bus.addr < `PIMU_REG_CTRL;
    end
  end

  // Outputs
  assign rdata = rd_mask_q ? {16'h0000, mem_rdata} : s_q.rdata;
  assign irq_req = s_q.grant.valid;
  assign irq_num = s_q.grant.num;
  assign error_flag = s_q.err;
  assign src_rd = s_q.src_rd;
  assign src_addr = s_q.src_addr;

  property p_lowest;
    @(posedge clk) disable iff (rst)
      (ce && s_d.grant.valid) |->
        (elig[s_d.grant.num] && ((elig & ((256'h1 << s_d.grant.num) - 256'h1)) == 256'h0));
  endproperty
  a_lowest: assert property (p_lowest) else $error("grant not lowest");

  property p_masked;
    @(posedge clk) disable iff (rst) (ce && s_d.grant.valid) |-> mask[s_d.grant.num];
  endproperty
  a_masked: assert property (p_masked) else $error("masked granted");

  property p_gie;
    @(posedge clk) disable iff (rst) s_q.grant.valid |-> $past(s_q.gie);
  endproperty
  a_gie: assert property (p_gie) else $error("grant while disabled");

  property p_busy;
    @(posedge clk) disable iff (rst) s_q.grant.valid |-> !$past(s_q.busy);
  endproperty
  a_busy: assert property (p_busy) else $error("grant during service");

  property p_err;
    @(posedge clk) disable iff (rst) $rose(s_q.err) |-> s_q.err_code == `PIMU_ERR_RANGE;
  endproperty
  a_err: assert property (p_err) else $error("wrong error code");

  property p_per;
    @(posedge clk) disable iff (rst) s_q.per[0] >= 10'd1 && s_q.per[0] <= 10'd1000;
  endproperty
  a_per: assert property (p_per) else $error("period out of range");

  property p_load;
    @(posedge clk) disable iff (rst || !ce) (s_q.fsm == PIMU_FETCH && s_q.idx == 4'h0) |-> ##[1:40] s_q.fsm == PIMU_IDLE;
  endproperty
  a_load: assert property (p_load) else $error("mask load stuck");

  property p_latch;
    @(posedge clk) disable iff (rst) (ce && raw[1] && !s_q.gie) |=> s_q.pend[1];
  endproperty
  a_latch: assert property (p_latch) else $error("request lost");

  property p_supply;
    @(posedge clk) disable iff (rst) (ce && supply_bad && !s_q.grant.valid) |=> s_q.pend[34] || s_q.grant.valid;
  endproperty
  a_supply: assert property (p_supply) else $error("supply fault lost");
endmodule : pimu_top

// File: hdl/pimu_word_mem.sv
`timescale 1ns/1ps
`include "pimu_cfg.svh"
// Sixteen-word mask bank, registered read port
module pimu_word_mem
  import pimu_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic         we,
  input  wire logic [3:0]   waddr,
  input  wire logic [15:0]  wdata,
  input  wire logic [3:0]   raddr,
  output logic      [15:0]  rdata,
  output logic      [255:0] flat
);
  logic [15:0] mem_q [16];
  logic [15:0] rdata_q;

  // Write port and registered read
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < 16; i++) mem_q[i] <= 16'h0000;
      rdata_q <= 16'h0000;
    end else if (ce) begin
      if (we) mem_q[waddr] <= wdata;
      rdata_q <= mem_q[raddr];
    end
  end
  assign rdata = rdata_q;

  // word w bit b gates interrupt 16*w+b
  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : g_flat
      assign flat[g*16 +: 16] = mem_q[g];
    end
  endgenerate
endmodule : pimu_word_mem

// File: verif/pimu_src_mem.sv
`timescale 1ns/1ps
// Source word memory answering mask-load fetches
module pimu_src_mem (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        src_rd,
  input  wire logic [15:0] src_addr,
  output logic      [15:0] src_data
);
  logic [15:0] mem [0:255];
  logic        valid_q;
  logic [7:0]  addr_q;
  logic [15:0] last_q;

  // Empty store unless the bench fills it
  initial begin
    for (int k = 0; k < 256; k++) mem[k] = 16'h0000;
  end

  // Capture fetch, remember last word driven
  always_ff @(posedge clk) begin
    valid_q <= rst ? 1'b0 : src_rd;
    if (src_rd) addr_q <= src_addr[7:0];
    if (valid_q) last_q <= mem[addr_q];
  end

  // Word only in the answer cycle, inverted junk otherwise
  assign src_data = valid_q ? mem[addr_q] : ~last_q;
endmodule : pimu_src_mem

// File: verif/tb.sv
`timescale 1ns/1ps
`include "pimu_cfg.svh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin errors++; $display("ERROR %0t got %h exp %h", $time, a, b); end end
module tb
  import pimu_pkg::*;
;
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  logic         ce = 1'b1;
  logic [7:0]   addr = 8'h00;
  logic [31:0]  wdata = 32'h0;
  logic         wr = 1'b0;
  logic         rd = 1'b0;
  logic [31:0]  rdata;
  logic [33:0]  io_irq = 34'h0;
  logic         supply_bad = 1'b0;
  logic [211:0] ext_irq = '0;
  logic         src_rd, irq_req, error_flag;
  logic [15:0]  src_addr, src_data;
  logic [7:0]   irq_num;
  logic [9:0]   per_dflt [0:3] = '{10'd100, 10'd40, 10'd20, 10'd10};
  int           errors = 0;
  int           compares = 0;
  int           n;

  // 40 MHz clock
  always #12.5 clk = ~clk;

  pimu_top i_pimu_top (.clk(clk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .io_irq(io_irq), .supply_bad(supply_bad), .ext_irq(ext_irq), .src_rd(src_rd),
    .src_addr(src_addr), .src_data(src_data), .irq_req(irq_req), .irq_num(irq_num), .error_flag(error_flag));
  pimu_src_mem i_pimu_src_mem (.clk(clk), .rst(rst), .src_rd(src_rd), .src_addr(src_addr), .src_data(src_data));

  task end_of_test;
    if (errors == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_of_test

  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wr_reg

  task rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    `CHK(rdata, e)
  endtask : rd_chk

  task no_grant(input int k);
    repeat (k) begin
      @(posedge clk);
      #1;
      `CHK(irq_req, 1'b0)
    end
  endtask : no_grant

  // Wait for a grant, hold service a while, then finish it
  task wait_grant(input logic [7:0] e);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (irq_req !== 1'b1 && n < 45000);
    if (n >= 45000) begin
      `CHK(1'b0, 1'b1)
      end_of_test;
    end
    `CHK(irq_num, e)
    no_grant(4);
    wr_reg(`PIMU_REG_CTRL, 32'h8);
  endtask : wait_grant

  task pulse_io(input logic [33:0] v);
    @(posedge clk);
    io_irq <= v;
    @(posedge clk);
    io_irq <= 34'h0;
  endtask : pulse_io

  task pulse_supply;
    @(posedge clk);
    supply_bad <= 1'b1;
    @(posedge clk);
    supply_bad <= 1'b0;
  endtask : pulse_supply

  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    for (int k = 0; k < 4; k++) rd_chk(`PIMU_REG_PER0 + 8'(4 * k), {22'h0, per_dflt[k]});
    rd_chk(`PIMU_REG_STATUS, 32'h0);
    rd_chk(`PIMU_REG_MASK0, 32'h0);
    wr_reg(`PIMU_REG_PER0 + 8'h0c, 32'd1);
    wr_reg(`PIMU_REG_PER0, 32'd0);
    wr_reg(`PIMU_REG_PER0, 32'd1001);
    rd_chk(`PIMU_REG_PER0, 32'd100);
    wr_reg(`PIMU_REG_PER0, 32'd1000);
    rd_chk(`PIMU_REG_PER0, 32'd1000);
    rd_chk(`PIMU_REG_PER0 + 8'h0c, 32'd1);
    // Source words: irq 1,2 in word 0, irq 34, timer 255, 16'h1111 * w patterns in words 1 and 3 to 14
    for (int w = 1; w < 15; w++) i_pimu_src_mem.mem[16 + w] = 16'(16'h1111 * w);
    i_pimu_src_mem.mem[16] = 16'h0006;
    i_pimu_src_mem.mem[18] = 16'h0004;
    i_pimu_src_mem.mem[31] = 16'h8000;
    wr_reg(`PIMU_REG_CTRL, {16'h0010, 16'h0004});
    repeat (40) @(posedge clk);
    for (int w = 0; w < 16; w++) rd_chk(8'(4 * w), {16'h0, i_pimu_src_mem.mem[16 + w]});
    pulse_io(34'h2);
    no_grant(6);
    wr_reg(`PIMU_REG_CTRL, 32'h1);
    wait_grant(8'd1);
    pulse_io(34'h7);
    wait_grant(8'd1);
    wait_grant(8'd2);
    no_grant(10);
    pulse_supply;
    wait_grant(8'd34);
    wr_reg(`PIMU_REG_CTRL, 32'h2);
    pulse_supply;
    no_grant(6);
    wr_reg(`PIMU_REG_CTRL, 32'h1);
    wait_grant(8'd34);
    // Start beyond the source range
    wr_reg(`PIMU_REG_CTRL, 32'hffff_0004);
    repeat (40) @(posedge clk);
    `CHK(error_flag, 1'b1)
    rd_chk(`PIMU_REG_ERRCODE, 32'h2003);
    rd_chk(`PIMU_REG_MASK0, 32'h0006);
    wait_grant(8'd255);
    wait_grant(8'd255);
    `CHK(n > 39990 && n < 39998, 1'b1)
    end_of_test;
  end
endmodule : tb
